// File: logic/acsc_regs.svh
// Timing constants for the converter clock generator
`ifndef ACSC_REGS_SVH
`define ACSC_REGS_SVH
`define ACSC_LOW_CYCLES 2'h2
`define ACSC_SYNC_STAGES 2
`define ACSC_CLK_RESET 1'b1
`endif

// File: logic/acsc_pkg.sv
// Types for the converter clock generator
`default_nettype none
package acsc_pkg;
    typedef enum logic [1:0] {
        ACSC_IDLE = 2'b00,
        ACSC_SAMPLE = 2'b01,
        ACSC_OFFSET = 2'b10,
        ACSC_GAIN = 2'b11
    } acsc_stage_t;

    typedef struct packed {
        logic sampler_strobe;
        logic offset_strobe;
        logic gain_strobe;
    } acsc_stage_strobes_t;
endpackage : acsc_pkg
`default_nettype wire

// File: logic/acsc_top.sv
// Converter clock generation from the asynchronous sample clock
// Notes on behaviour
// - Sample clock steps sampler, offset, gain stages
// - Resynchronise sample clock into master domain
// - Converter clocked from the master clock
// - Converter clock falls on captured sample fall
// - Low two master cycles after the last captured fall, then high
// - Stays high until next captured fall
`include "acsc_regs.svh"
`default_nettype none
module acsc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Sample clock pin
    input wire logic sample_clock_in,
    // Converter clock and stage sequencing
    output logic conv_clk,
    output logic conv_strobe,
    output acsc_pkg::acsc_stage_t stage,
    output acsc_pkg::acsc_stage_strobes_t stage_strobes
);
    logic [`ACSC_SYNC_STAGES-1:0] sync_chain;
    logic sync_prev;
    logic [1:0] low_count;
    acsc_pkg::acsc_stage_t next_stage;
    acsc_pkg::acsc_stage_strobes_t next_strobes;
    logic next_conv_clk;
    logic [1:0] next_low_count;

    // Only the second stage is looked at; the first may be metastable
    wire logic sync_level = sync_chain[`ACSC_SYNC_STAGES-1];
    wire logic fall_seen = sync_prev & ~sync_level;
    wire logic rise_seen = ~sync_prev & sync_level;
    wire logic low_done = (low_count == `ACSC_LOW_CYCLES - 2'h1);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sync_chain <= '0;
            sync_prev <= 1'b0;
        end else begin
            sync_chain <= {sync_chain[`ACSC_SYNC_STAGES-2:0], sample_clock_in};
            sync_prev <= sync_level;
        end
    end

    // A fall arriving while low restarts the low window rather than being lost
    always_comb begin
        next_conv_clk = conv_clk;
        next_low_count = low_count;
        if (fall_seen) begin
            next_conv_clk = 1'b0;
            next_low_count = 2'h0;
        end else if (!conv_clk) begin
            if (low_done) begin
                next_conv_clk = 1'b1;
            end else begin
                next_low_count = low_count + 2'h1;
            end
        end
    end

    // Stage walk: sampler on the captured fall, then offset and gain on the next two cycles.
    // Timed from the fall, so a fall that arrives before gain is reached restarts the walk at the sampler stage.
    always_comb begin
        next_stage = stage;
        if (fall_seen) begin
            next_stage = acsc_pkg::ACSC_SAMPLE;
        end else begin
            unique case (stage)
                acsc_pkg::ACSC_SAMPLE: next_stage = acsc_pkg::ACSC_OFFSET;
                acsc_pkg::ACSC_OFFSET: next_stage = acsc_pkg::ACSC_GAIN;
                acsc_pkg::ACSC_GAIN: next_stage = acsc_pkg::ACSC_GAIN;
                acsc_pkg::ACSC_IDLE: next_stage = acsc_pkg::ACSC_IDLE;
            endcase
        end
        next_strobes.sampler_strobe = (next_stage == acsc_pkg::ACSC_SAMPLE) && (stage != next_stage);
        next_strobes.offset_strobe = (next_stage == acsc_pkg::ACSC_OFFSET) && (stage != next_stage);
        next_strobes.gain_strobe = (next_stage == acsc_pkg::ACSC_GAIN) && (stage != next_stage);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            conv_clk <= `ACSC_CLK_RESET;
            low_count <= 2'h0;
            conv_strobe <= 1'b0;
            stage <= acsc_pkg::ACSC_IDLE;
            stage_strobes <= '0;
        end else begin
            conv_clk <= next_conv_clk;
            low_count <= next_low_count;
            conv_strobe <= next_conv_clk & ~conv_clk;
            stage <= next_stage;
            stage_strobes <= next_strobes;
        end
    end

    property p_fall_drops_clk;
        @(posedge core_clk) disable iff (srst)
        fall_seen |=> !conv_clk;
    endproperty
    a_fall_drops_clk: assert property (p_fall_drops_clk) else $error("clock not low after fall");

    property p_low_two;
        @(posedge core_clk) disable iff (srst)
        ($fell(conv_clk) && !fall_seen) ##1 !fall_seen |=> conv_clk;
    endproperty
    a_low_two: assert property (p_low_two) else $error("low phase not two cycles");

    property p_low_min;
        @(posedge core_clk) disable iff (srst)
        $fell(conv_clk) |=> !conv_clk;
    endproperty
    a_low_min: assert property (p_low_min) else $error("low phase too short");

    property p_hold_high;
        @(posedge core_clk) disable iff (srst)
        conv_clk && !fall_seen |=> conv_clk;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("clock fell without fall");

    property p_sync_delay;
        @(posedge core_clk) disable iff (srst)
        $fell(sample_clock_in) ##1 !sample_clock_in ##1 !sample_clock_in |-> ##[0:1] !sync_level;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong");

    property p_sample_stage;
        @(posedge core_clk) disable iff (srst)
        fall_seen |=> stage == acsc_pkg::ACSC_SAMPLE && stage_strobes.sampler_strobe;
    endproperty
    a_sample_stage: assert property (p_sample_stage) else $error("sampler not started");

    property p_strobe_rise;
        @(posedge core_clk) disable iff (srst)
        conv_strobe |-> conv_clk && $past(conv_clk, 2) == 1'b0;
    endproperty
    a_strobe_rise: assert property (p_strobe_rise) else $error("strobe not on rise");

    // A sample-clock rise must never disturb the converter clock
    property p_rise_keeps_high;
        @(posedge core_clk) disable iff (srst)
        rise_seen && conv_clk |=> conv_clk;
    endproperty
    a_rise_keeps_high: assert property (p_rise_keeps_high) else $error("rise moved clock");

    property p_offset_next;
        @(posedge core_clk) disable iff (srst)
        stage == acsc_pkg::ACSC_SAMPLE && !fall_seen |=>
            stage == acsc_pkg::ACSC_OFFSET && stage_strobes.offset_strobe;
    endproperty
    a_offset_next: assert property (p_offset_next) else $error("offset did not follow");

    property p_gain_next;
        @(posedge core_clk) disable iff (srst)
        stage == acsc_pkg::ACSC_OFFSET && !fall_seen |=>
            stage == acsc_pkg::ACSC_GAIN && stage_strobes.gain_strobe;
    endproperty
    a_gain_next: assert property (p_gain_next) else $error("gain did not follow");

    property p_strobe_onehot;
        @(posedge core_clk) disable iff (srst)
        $onehot0(stage_strobes);
    endproperty
    a_strobe_onehot: assert property (p_strobe_onehot) else $error("stage strobes overlap");

    property p_gain_pulse;
        @(posedge core_clk) disable iff (srst)
        stage_strobes.gain_strobe |=> !stage_strobes.gain_strobe;
    endproperty
    a_gain_pulse: assert property (p_gain_pulse) else $error("gain strobe too long");

    property p_idle_until_fall;
        @(posedge core_clk) disable iff (srst)
        stage == acsc_pkg::ACSC_IDLE && !fall_seen |=> stage == acsc_pkg::ACSC_IDLE;
    endproperty
    a_idle_until_fall: assert property (p_idle_until_fall) else $error("left idle early");

    property p_conv_pulse;
        @(posedge core_clk) disable iff (srst)
        conv_strobe |=> !conv_strobe;
    endproperty
    a_conv_pulse: assert property (p_conv_pulse) else $error("converter strobe too long");

    property p_strobe_on_rise;
        @(posedge core_clk) disable iff (srst)
        $rose(conv_clk) |-> conv_strobe;
    endproperty
    a_strobe_on_rise: assert property (p_strobe_on_rise) else $error("rise without strobe");

    // The low counter never passes the end of its window
    property p_count_range;
        @(posedge core_clk) disable iff (srst)
        !conv_clk |-> low_count < `ACSC_LOW_CYCLES;
    endproperty
    a_count_range: assert property (p_count_range) else $error("low count overran");

    property p_count_start;
        @(posedge core_clk) disable iff (srst)
        $fell(conv_clk) |-> low_count == 2'h0;
    endproperty
    a_count_start: assert property (p_count_start) else $error("low count not cleared");

    property p_rise_at_end;
        @(posedge core_clk) disable iff (srst)
        $rose(conv_clk) |-> $past(low_count) == `ACSC_LOW_CYCLES - 2'h1;
    endproperty
    a_rise_at_end: assert property (p_rise_at_end) else $error("rise before window end");

    // A detected fall must come from the second flop, one cycle behind the first
    property p_fall_from_chain;
        @(posedge core_clk) disable iff (srst)
        fall_seen |-> $past(sync_chain[0]) == 1'b0;
    endproperty
    a_fall_from_chain: assert property (p_fall_from_chain) else $error("fall skipped a stage");

    property p_high_needs_fall;
        @(posedge core_clk) disable iff (srst)
        $fell(conv_clk) |-> $past(fall_seen);
    endproperty
    a_high_needs_fall: assert property (p_high_needs_fall) else $error("fell with no fall");
endmodule : acsc_top
`default_nettype wire

// File: tb/acsc_partner.sv
// Scanner timing controller model driving the sample clock
`default_nettype none
module acsc_partner (
    // Master clock and pacing
    input wire logic core_clk,
    input wire logic run,
    input wire logic [2:0] hi_len,
    input wire logic [2:0] lo_len,
    // Sample clock pin
    output logic sample_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial sample_clock_in = 1'b0;
    // Edges land on falling master edges only, away from converter edges
    always @(negedge core_clk) begin
        if (!run) begin
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            sample_clock_in <= ~sample_clock_in;
            cnt <= int'(sample_clock_in ? lo_len : hi_len) - 1;
        end
    end
endmodule : acsc_partner
`default_nettype wire

// File: tb/acsc_top_tb.sv
// Self-checking bench for the converter clock generator
`default_nettype none
module acsc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, srst = 1'b1, run = 1'b0, sample_clock_in, conv_clk, conv_strobe;
    logic s1, s2, prev, exp_clk, exp_stb, fall_d;
    logic [2:0] exp_strb;
    acsc_pkg::acsc_stage_t exp_stg;
    logic [2:0] hi_len = 3'h1, lo_len = 3'h1;
    logic [1:0] cnt;
    acsc_pkg::acsc_stage_t stage;
    acsc_pkg::acsc_stage_strobes_t stage_strobes;
    int err_count = 0, comparisons = 0;
    wire fall = prev & ~s2;
    acsc_top u_dut (.core_clk(core_clk), .srst(srst), .sample_clock_in(sample_clock_in),
        .conv_clk(conv_clk), .conv_strobe(conv_strobe), .stage(stage),
        .stage_strobes(stage_strobes));
    acsc_partner u_far (.core_clk(core_clk), .run(run), .hi_len(hi_len), .lo_len(lo_len),
        .sample_clock_in(sample_clock_in));
    initial forever #5 core_clk = ~core_clk;
    task automatic check(input logic [2:0] seen, input logic [2:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen %b expected %b", $time, seen, want);
        end
    endtask : check
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // Reference: two-stage sync, fall detect, two-cycle low restartable by a new fall
    always @(posedge core_clk) begin
        if (srst) begin
            {s1, s2, prev, exp_stb, fall_d, cnt, exp_strb} <= '0;
            exp_clk <= 1'b1;
            exp_stg <= acsc_pkg::ACSC_IDLE;
        end else begin
            s1 <= sample_clock_in;
            s2 <= s1;
            prev <= s2;
            fall_d <= fall;
            exp_stb <= !fall && cnt == 2'h1;
            exp_strb <= {fall && exp_stg != acsc_pkg::ACSC_SAMPLE,
                !fall && exp_stg == acsc_pkg::ACSC_SAMPLE, !fall && exp_stg == acsc_pkg::ACSC_OFFSET};
            if (fall) exp_stg <= acsc_pkg::ACSC_SAMPLE;
            else if (exp_stg == acsc_pkg::ACSC_SAMPLE) exp_stg <= acsc_pkg::ACSC_OFFSET;
            else if (exp_stg == acsc_pkg::ACSC_OFFSET) exp_stg <= acsc_pkg::ACSC_GAIN;
            if (fall) begin
                cnt <= 2'h2;
                exp_clk <= 1'b0;
            end else if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
                exp_clk <= (cnt == 2'h1);
            end
        end
    end
    always @(negedge core_clk) begin
        if (!srst) begin
            check({2'b00, conv_clk}, {2'b00, exp_clk});
            check({2'b00, conv_strobe}, {2'b00, exp_stb});
            check({2'b00, stage_strobes.sampler_strobe}, {2'b00, fall_d});
            if (fall_d) check({1'b0, stage}, {1'b0, acsc_pkg::ACSC_SAMPLE});
            check({1'b0, stage}, {1'b0, exp_stg});
            check(stage_strobes, exp_strb);
        end
    end
    initial begin
        #600000;
        err_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hf6fa7bf1));
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
        repeat (3) @(negedge core_clk);
        run <= 1'b1;
        // Corners: refall inside the low window, then slow edges, then random pacing
        repeat (40) @(negedge core_clk);
        {hi_len, lo_len} <= {3'h7, 3'h7};
        repeat (60) @(negedge core_clk);
        repeat (200) begin
            hi_len <= 3'($urandom_range(7, 1));
            lo_len <= 3'($urandom_range(7, 1));
            repeat (16) @(negedge core_clk);
        end
        wrap_up();
    end
endmodule : acsc_top_tb
`default_nettype wire
